// ==== pkg/fscs_pkg.sv ====
// Package: constants and types for the configuration byte store
package fscs_pkg;

  // ==========================================================================
  // Byte select of the programming port
  localparam logic [1:0] SEL_LOW  = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_EXT  = 2'h2;
  localparam logic [1:0] SEL_LOCK = 2'h3;

  // ==========================================================================
  // Signature space offsets
  localparam logic [1:0] SIG_BYTE0_OFF = 2'h0;
  localparam logic [1:0] SIG_BYTE1_OFF = 2'h1;
  localparam logic [1:0] SIG_BYTE2_OFF = 2'h2;

  // ==========================================================================
  // Default values, 0 means programmed
  localparam logic [7:0] EXT_RESET     = 8'hff;
  localparam logic [7:0] HIGH_RESET    = 8'h99;
  localparam logic [7:0] LOW_RESET     = 8'h62;
  localparam logic [7:0] EXT_USED_MASK = 8'h07;
  localparam logic [7:0] LOCK_RESET    = 8'hff;

  // ==========================================================================
  // Field positions
  localparam int HI_DEBUG_BIT    = 7;
  localparam int HI_SCAN_BIT     = 6;
  localparam int HI_SERIAL_BIT   = 5;
  localparam int HI_WDOG_BIT     = 4;
  localparam int HI_PRESERVE_BIT = 3;
  localparam int HI_BOOT_HI      = 2;
  localparam int HI_BOOT_LO      = 1;
  localparam int HI_VECTOR_BIT   = 0;
  localparam int LO_DIV8_BIT     = 7;
  localparam int LO_SYSTEM_CLOCK_OUTPUT_ENABLE_BIT    = 6;
  localparam int LO_SUT_HI       = 5;
  localparam int LO_SUT_LO       = 4;
  localparam int LO_CKSRC_HI     = 3;
  localparam int LOCK_LB1_BIT    = 0;

  // ==========================================================================
  // Page organisation
  localparam int FLASH_WORD_BITS        = 7;
  localparam int flash_address_top_bit  = 16;
  localparam int EE_BYTE_BITS           = 3;
  localparam int eeprom_address_top_bit = 11;

  // ==========================================================================
  // Decoded configuration, active high after inversion
  typedef struct packed {
    logic [2:0] brownout_level;
    logic       onchip_debug_enable;
    logic       boundary_scan_port_enable;
    logic       serial_download_enable;
    logic       watchdog_force_on;
    logic       eeprom_preserve_on_erase;
    logic [1:0] boot_size;
    logic       reset_vector_select;
    logic       clock_divide_by_eight;
    logic       system_clock_output_enable;
    logic [1:0] startup_time;
    logic [3:0] clock_source;
  } fscs_cfg_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       sig_rd;
    logic       serial;
    logic [1:0] sel;
    logic [1:0] addr;
    logic [7:0] wdata;
  } fscs_req_s;

endpackage : fscs_pkg

// ==== hdl/fscs_store.sv ====
// Module: fuse bytes, signature space, calibration copy and page split
`timescale 1ns/1ps
// ============================================================================
// Function
// - Fuse reads return 0 for programmed bits and 1 for unprogrammed ones.
// - Extended byte bits 2:0 brown-out level, bits 7:3 always read 1.
// - High bit 7 debug enable off by default, bit 6 scan port on.
// - High bit 5 serial download enable, programmed, unchangeable over serial port.
// - High bit 4 forces watchdog, bit 3 preserves EEPROM; both unprogrammed.
// - High bits 2:1 boot size both programmed; bit 0 reset vector unprogrammed.
// - Low bit 7 divides clock by 8 default on; bit 6 drives clock pin.
// - Low bits 5:4 start-up time, default unprogrammed then programmed.
// - Low bits 3:0 clock source default 0010, internal RC at 8MHz.
// - Chip erase leaves all fuse bytes unchanged.
// - Fuse writes refused while memory lock bit 1 is programmed.
// - Fuses latched on programming mode entry, held past the mode end until the next entry or power-up.
// - EEPROM-preserve fuse acts at once when programmed, even in programming mode.
// - Fuses also latched at power-up in normal mode.
// - Three signature bytes at 0x000-0x002, readable always, even when locked.
// - Calibration byte sits in high byte of signature address 0x000.
// - Each reset copies the calibration byte into the oscillator calibration register.
// - Flash is 1024 pages of 128 words, PC 6:0 word, 16:7 page.
// - EEPROM is 512 pages of 8 bytes, address 2:0 byte, 11:3 page.
module fscs_store
  import fscs_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identification value
  parameter logic [7:0] SIG_BYTE1 = 8'ha5, // Arbitrary identification value
  parameter logic [7:0] SIG_BYTE2 = 8'h3c, // Arbitrary identification value
  parameter logic [7:0] CAL_BYTE  = 8'h80
)(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  input  wire logic                          prog_mode,
  input  wire fscs_req_s                     req,
  input  wire logic                          chip_erase,
  input  wire logic [7:0]                    lock_byte,
  input  wire logic [flash_address_top_bit:0]  pc,
  input  wire logic [eeprom_address_top_bit:0] ee_addr,
  output logic [7:0]                         rdata,
  output logic                               rvalid,
  output logic                               wr_refused,
  output fscs_cfg_s                          cfg,
  output logic [7:0]                         rc_oscillator_calibration_reg,
  output logic [FLASH_WORD_BITS-1:0]         flash_word_in_page,
  output logic [flash_address_top_bit-FLASH_WORD_BITS:0] flash_page_index,
  output logic [EE_BYTE_BITS-1:0]            eeprom_byte_in_page,
  output logic [eeprom_address_top_bit-EE_BYTE_BITS:0]   eeprom_page_index
);

  // ==========================================================================
  // Stored bytes; a programmed bit is held as 0
  logic [7:0] ext_q;
  logic [7:0] high_q;
  logic [7:0] low_q;
  logic [7:0] ext_lat_q;
  logic [7:0] high_lat_q;
  logic [7:0] low_lat_q;
  logic       prog_mode_q;
  logic       powerup_q;
  logic       locked;
  logic       wr_ok;
  logic       wr_low;
  logic       wr_high;
  logic       wr_ext;
  logic [7:0] high_wdata;
  logic [7:0] ext_wdata;
  logic       mode_entry;
  logic       powerup_latch;
  logic       latch_now;
  logic       preserve_now;
  logic [7:0] fuse_rdata;
  logic [7:0] sig_rdata;

  // ==========================================================================
  // Write qualification
  // Only lock bit 1 blocks fuse writes
  // Writes to the lock byte are ignored; the lock bits live outside this block
  assign locked  = ~lock_byte[LOCK_LB1_BIT];
  assign wr_ok   = clk_en & req.wr & ~locked;
  assign wr_low  = wr_ok & (req.sel == SEL_LOW);
  assign wr_high = wr_ok & (req.sel == SEL_HIGH);
  assign wr_ext  = wr_ok & (req.sel == SEL_EXT);

  // ==========================================================================
  // Write data shaping
  // The serial port cannot reach the download enable, or it could lock itself out
  always_comb
  begin
    high_wdata = req.wdata;
    if (req.serial)
    begin
      high_wdata[HI_SERIAL_BIT] = high_q[HI_SERIAL_BIT];
    end
  end

  // Unused extended bits are forced to 1 on the way in
  assign ext_wdata = req.wdata | ~EXT_USED_MASK;

  // ==========================================================================
  // Non-volatile image; reset models the factory state since rst is power-up here
  // Chip erase has no path into these bytes at all
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_q <= LOW_RESET;
    end
    else if (wr_low)
    begin
      low_q <= req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      high_q <= HIGH_RESET;
    end
    else if (wr_high)
    begin
      high_q <= high_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_q <= EXT_RESET;
    end
    else if (wr_ext)
    begin
      ext_q <= ext_wdata;
    end
  end

  // ==========================================================================
  // Latch events: entry to programming mode, and the first enabled cycle after
  // power-up when starting in normal mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prog_mode_q <= 1'b0;
      powerup_q   <= 1'b1;
    end
    else if (clk_en)
    begin
      prog_mode_q <= prog_mode;
      powerup_q   <= 1'b0;
    end
  end

  assign mode_entry    = prog_mode & ~prog_mode_q;
  assign powerup_latch = powerup_q & ~prog_mode;
  assign latch_now     = clk_en & (mode_entry | powerup_latch);
  // A programmed preserve fuse acts at once; un-programming waits for a latch
  assign preserve_now  = clk_en & ~high_q[HI_PRESERVE_BIT];

  // ==========================================================================
  // Latched copies; they move on latch events, and the preserve bit also when it is programmed, so consumers never glitch
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_lat_q <= EXT_RESET;
    end
    else if (latch_now)
    begin
      ext_lat_q <= ext_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_lat_q <= LOW_RESET;
    end
    else if (latch_now)
    begin
      low_lat_q <= low_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      high_lat_q <= HIGH_RESET;
    end
    else if (latch_now)
    begin
      high_lat_q <= high_q;
    end
    else if (preserve_now)
    begin
      high_lat_q[HI_PRESERVE_BIT] <= 1'b0;
    end
  end

  // ==========================================================================
  // Decoded outputs, all from the latched copy
  always_comb
  begin
    cfg.brownout_level             = ~ext_lat_q[2:0];
    cfg.onchip_debug_enable        = ~high_lat_q[HI_DEBUG_BIT];
    cfg.boundary_scan_port_enable  = ~high_lat_q[HI_SCAN_BIT];
    cfg.serial_download_enable     = ~high_lat_q[HI_SERIAL_BIT];
    cfg.watchdog_force_on          = ~high_lat_q[HI_WDOG_BIT];
    cfg.eeprom_preserve_on_erase   = ~high_lat_q[HI_PRESERVE_BIT];
    cfg.boot_size                  = ~high_lat_q[HI_BOOT_HI:HI_BOOT_LO];
    cfg.reset_vector_select        = ~high_lat_q[HI_VECTOR_BIT];
    cfg.clock_divide_by_eight      = ~low_lat_q[LO_DIV8_BIT];
    cfg.system_clock_output_enable = ~low_lat_q[LO_SYSTEM_CLOCK_OUTPUT_ENABLE_BIT];
    cfg.startup_time               = ~low_lat_q[LO_SUT_HI:LO_SUT_LO];
    cfg.clock_source               = ~low_lat_q[LO_CKSRC_HI:0];
  end

  // ==========================================================================
  // Read port; signature reads ignore the lock state
  // Address 3 of the signature space is not populated and reads as all ones
  always_comb
  begin
    case (req.addr)
      SIG_BYTE0_OFF:
      begin
        sig_rdata = req.sel[0] ? CAL_BYTE : SIG_BYTE0;
      end
      SIG_BYTE1_OFF:
      begin
        sig_rdata = SIG_BYTE1;
      end
      SIG_BYTE2_OFF:
      begin
        sig_rdata = SIG_BYTE2;
      end
      default:
      begin
        sig_rdata = 8'hff;
      end
    endcase
  end

  // Raw stored bytes: programmed reads as 0
  always_comb
  begin
    case (req.sel)
      SEL_LOW:
      begin
        fuse_rdata = low_q;
      end
      SEL_HIGH:
      begin
        fuse_rdata = high_q;
      end
      SEL_EXT:
      begin
        fuse_rdata = ext_q | ~EXT_USED_MASK;
      end
      default:
      begin
        fuse_rdata = lock_byte;
      end
    endcase
  end

  // rdata holds until the next read so a slow programmer may still pick it up
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
    end
    else if (clk_en && req.sig_rd)
    begin
      rdata <= sig_rdata;
    end
    else if (clk_en && req.rd)
    begin
      rdata <= fuse_rdata;
    end
  end

  // Answer strobes, one cycle each
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid     <= 1'b0;
      wr_refused <= 1'b0;
    end
    else if (clk_en)
    begin
      rvalid     <= req.rd | req.sig_rd;
      wr_refused <= req.wr & locked;
    end
  end

  // ==========================================================================
  // Calibration copy during every reset; clk_en does not gate it so the
  // oscillator is trimmed even while the clock enable is held low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rc_oscillator_calibration_reg <= CAL_BYTE;
    end
  end

  // ==========================================================================
  // Page split of flash and EEPROM addresses
  // Registered so the split lines up with the other registered outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flash_word_in_page <= '0;
      flash_page_index   <= '0;
    end
    else if (clk_en)
    begin
      flash_word_in_page <= pc[FLASH_WORD_BITS-1:0];
      flash_page_index   <= pc[flash_address_top_bit:FLASH_WORD_BITS];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      eeprom_byte_in_page <= '0;
      eeprom_page_index   <= '0;
    end
    else if (clk_en)
    begin
      eeprom_byte_in_page <= ee_addr[EE_BYTE_BITS-1:0];
      eeprom_page_index   <= ee_addr[eeprom_address_top_bit:EE_BYTE_BITS];
    end
  end

  // ==========================================================================
  // Chip erase only reaches memories outside this block
  logic unused_erase;
  assign unused_erase = chip_erase;

endmodule : fscs_store

// ==== tb/fscs_store_monitor.sv ====
// Checker: port-level properties of the configuration store
`timescale 1ns/1ps
module fscs_store_monitor
  import fscs_pkg::*;
#(parameter logic [7:0] CAL_BYTE = 8'h80)(
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic                              clk_en,
  input wire logic                              prog_mode,
  input wire fscs_req_s                         req,
  input wire logic [7:0]                        lock_byte,
  input wire logic [flash_address_top_bit:0]    pc,
  input wire logic [eeprom_address_top_bit:0]  ee_addr,
  input wire logic [7:0]                        rdata,
  input wire logic                              rvalid,
  input wire logic                              wr_refused,
  input wire fscs_cfg_s                         cfg,
  input wire logic [7:0]                        rc_oscillator_calibration_reg,
  input wire logic [6:0]                        flash_word_in_page,
  input wire logic [9:0]                        flash_page_index,
  input wire logic [2:0]                        eeprom_byte_in_page,
  input wire logic [8:0]                        eeprom_page_index
);
  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  fscs_cfg_s cfg_m;
  // Preserve bit may move at any time, so it is left out of the hold check
  always_comb
  begin
    cfg_m = cfg;
    cfg_m.eeprom_preserve_on_erase = 1'b0;
  end
  sequence s_rd; clk_en && (req.rd || req.sig_rd); endsequence
  sequence s_bad_wr; clk_en && req.wr && !lock_byte[0]; endsequence
  sequence s_held; prog_mode [*4]; endsequence
  property p_rvalid; s_rd |=> rvalid; endproperty
  property p_refuse; s_bad_wr |=> wr_refused; endproperty
  property p_accept; clk_en && req.wr && lock_byte[0] |=> !wr_refused; endproperty
  property p_ext; rvalid && $past(req.rd && !req.sig_rd && req.sel == SEL_EXT)
    |-> (rdata | EXT_USED_MASK) == 8'hff; endproperty
  property p_cal; disable iff (1'b0) $fell(rst) |-> rc_oscillator_calibration_reg == CAL_BYTE;
  endproperty
  property p_flash; clk_en |=> flash_page_index == $past(pc[16:7])
    && flash_word_in_page == $past(pc[6:0]); endproperty
  property p_ee; clk_en |=> eeprom_page_index == $past(ee_addr[11:3])
    && eeprom_byte_in_page == $past(ee_addr[2:0]); endproperty
  property p_hold; s_held |-> $stable(cfg_m); endproperty
  property p_keep; clk_en && req.wr && lock_byte[0] && req.sel == SEL_HIGH
    && !req.wdata[HI_PRESERVE_BIT] |-> ##[1:2] cfg.eeprom_preserve_on_erase; endproperty
  a_rvalid: assert property (p_rvalid) else $error("no read answer");
  a_refuse: assert property (p_refuse) else $error("locked write not refused");
  a_accept: assert property (p_accept) else $error("open write refused");
  a_ext: assert property (p_ext) else $error("unused ext bits not 1");
  a_cal: assert property (p_cal) else $error("calibration not loaded");
  a_flash: assert property (p_flash) else $error("flash split wrong");
  a_ee: assert property (p_ee) else $error("eeprom split wrong");
  a_hold: assert property (p_hold) else $error("cfg moved in mode");
  a_keep: assert property (p_keep) else $error("preserve late");
endmodule : fscs_store_monitor

// ==== tb/fscs_prog_model.sv ====
// Partner: external programmer on the programming port
`timescale 1ns/1ps
module fscs_prog_model
  import fscs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  input  wire logic       wr_refused,
  output fscs_req_s       req,
  output logic [7:0]      lock_byte
);
  // ==========================================================================
  // Requests, one pulse each, answer sampled one cycle after it is taken
  initial req = '0;
  initial lock_byte = LOCK_RESET;
  task automatic access(input fscs_req_s r, output logic [7:0] q, output logic v,
                        output logic rf);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    q = rdata;
    v = rvalid;
    rf = wr_refused;
  endtask : access
  // Called only after fuse writes: lock bit 1 would freeze them
  task automatic lock(input logic [7:0] val);
    @(posedge clk);
    lock_byte <= val;
  endtask : lock
endmodule : fscs_prog_model

// ==== tb/tb.sv ====
// Testbench: self-checking bench for the configuration store
`timescale 1ns/1ps
module tb;
  import fscs_pkg::*;
  // ==========================================================================
  // Signals
  logic clk, rst, clk_en, prog_mode, chip_erase, v, rf;
  logic [16:0] pc;
  logic [11:0] ee_addr;
  logic [7:0] q, lock_byte, rdata, rc;
  logic [6:0] fw;
  logic [9:0] fp;
  logic [2:0] eb;
  logic [8:0] ep;
  logic rvalid, wr_refused;
  fscs_req_s req;
  fscs_cfg_s cfg;
  int n_fail, compares;
  localparam logic [7:0] SIG [3] = '{8'h5a, 8'ha5, 8'h3c}; // Arbitrary values
  localparam fscs_cfg_s DEF = '{3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h3, 1'b0, 1'b1,
                                1'b0, 2'h1, 4'hd};
  fscs_store #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2])) u_fscs_store (
    .clk(clk), .rst(rst), .clk_en(clk_en), .prog_mode(prog_mode), .req(req),
    .chip_erase(chip_erase), .lock_byte(lock_byte), .pc(pc), .ee_addr(ee_addr),
    .rdata(rdata), .rvalid(rvalid), .wr_refused(wr_refused), .cfg(cfg),
    .rc_oscillator_calibration_reg(rc), .flash_word_in_page(fw), .flash_page_index(fp),
    .eeprom_byte_in_page(eb), .eeprom_page_index(ep));
  fscs_prog_model u_fscs_prog_model (.clk(clk), .rdata(rdata), .rvalid(rvalid),
    .wr_refused(wr_refused), .req(req), .lock_byte(lock_byte));
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, r, s, ser, input logic [1:0] sl, a, input logic [7:0] d);
    u_fscs_prog_model.access('{w, r, s, ser, sl, a, d}, q, v, rf);
  endtask : acc
  task automatic rd_chk(input logic [1:0] sl, input logic [7:0] exp);
    acc(0, 1, 0, 0, sl, 2'h0, 8'h00);
    chk({v, q}, {1'b1, exp});
  endtask : rd_chk
  task automatic mode(input logic m);
    @(posedge clk);
    prog_mode <= m;
    repeat (3) @(posedge clk);
  endtask : mode
  // ==========================================================================
  // Scenarios
  task automatic t_defaults;
    rd_chk(SEL_LOW, 8'h62);
    rd_chk(SEL_HIGH, 8'h99);
    rd_chk(SEL_EXT, 8'hff);
    chk(cfg, DEF);
    chk(rc, 8'h80);
  endtask : t_defaults
  task automatic t_latch;
    acc(1, 0, 0, 0, SEL_LOW, 2'h0, 8'h55);
    rd_chk(SEL_LOW, 8'h55);
    chk(cfg.clock_source, 4'hd);
    mode(1);
    chk(cfg.clock_source, 4'ha);
    acc(1, 0, 0, 0, SEL_LOW, 2'h0, 8'hff);
    acc(1, 0, 0, 0, SEL_EXT, 2'h0, 8'h00);
    rd_chk(SEL_EXT, 8'hf8);
    acc(1, 0, 0, 0, SEL_HIGH, 2'h0, 8'he7);
    acc(1, 0, 0, 1, SEL_HIGH, 2'h0, 8'hc7);
    rd_chk(SEL_HIGH, 8'he7);
    chk({cfg.watchdog_force_on, cfg.eeprom_preserve_on_erase}, 2'b01);
    mode(0);
    mode(1);
    chk({cfg.watchdog_force_on, cfg.clock_source}, 5'h10);
    mode(0);
  endtask : t_latch
  task automatic t_erase_lock;
    @(posedge clk);
    chip_erase <= 1;
    @(posedge clk);
    chip_erase <= 0;
    rd_chk(SEL_LOW, 8'hff);
    rd_chk(SEL_HIGH, 8'he7);
    rd_chk(SEL_EXT, 8'hf8);
    u_fscs_prog_model.lock(8'hfe);
    acc(1, 0, 0, 0, SEL_LOW, 2'h0, 8'h00);
    chk(rf, 1'b1);
    rd_chk(SEL_LOW, 8'hff);
    rd_chk(SEL_LOCK, 8'hfe);
    acc(0, 0, 1, 0, 2'h0, 2'h3, 8'h00);
    chk({v, q}, 9'h1ff);
    for (int i = 0; i < 3; i++)
    begin
      acc(0, 0, 1, 0, 2'h0, 2'(i), 8'h00);
      chk({v, q}, {1'b1, SIG[i]});
    end
    acc(0, 0, 1, 0, 2'h1, 2'h0, 8'h00);
    chk({v, q}, {1'b1, 8'h80});
    u_fscs_prog_model.lock(8'hff);
  endtask : t_erase_lock
  task automatic t_split;
    @(posedge clk);
    pc <= 17'h1ff85;
    ee_addr <= 12'hfa3;
    repeat (2) @(posedge clk);
    chk({fp, fw, ep, eb}, {10'h3ff, 7'h05, 9'h1f4, 3'h3});
    clk_en <= 0;
    pc <= '0;
    repeat (2) @(posedge clk);
    chk(fp, 10'h3ff);
    clk_en <= 1;
  endtask : t_split
  task automatic summarize;
    $display("Compares %0d, errors %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    prog_mode = 1'b0;
    chip_erase = 1'b0;
    pc = '0;
    ee_addr = '0;
    repeat (5) @(posedge clk);
    rst <= 0;
    t_defaults();
    t_latch();
    t_erase_lock();
    t_split();
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    t_defaults();
    summarize();
  end
endmodule : tb
bind fscs_store fscs_store_monitor #(.CAL_BYTE(CAL_BYTE)) u_fscs_store_monitor (
  .clk(clk), .rst(rst), .clk_en(clk_en), .prog_mode(prog_mode), .req(req),
  .lock_byte(lock_byte), .pc(pc), .ee_addr(ee_addr), .rdata(rdata), .rvalid(rvalid),
  .wr_refused(wr_refused), .cfg(cfg),
  .rc_oscillator_calibration_reg(rc_oscillator_calibration_reg),
  .flash_word_in_page(flash_word_in_page), .flash_page_index(flash_page_index),
  .eeprom_byte_in_page(eeprom_byte_in_page), .eeprom_page_index(eeprom_page_index));
